/* design/fps_supervisor.sv */
// Protection supervisor of a digital flyback controller: state, blanking and gate control.
// Assumes qualified comparator outputs synchronous to sys_clk and a modulator gate request.
module fps_supervisor
   import fps_pkg::*;
#(
   parameter int unsigned AR_OFF_CYCLES = fps_pkg::AR_OFF_CYC,
   parameter int unsigned BO_NORM_CYCLES = fps_pkg::BO_NORM_CYC,
   parameter int unsigned BO_SS_CYCLES = fps_pkg::BO_SS_CYC,
   parameter int unsigned SUP_OVP_CYCLES = fps_pkg::SUP_OVP_CYC,
   parameter int unsigned FB_HIGH_CYCLES = fps_pkg::FB_HIGH_CYC,
   parameter int unsigned OTP_CYCLES = fps_pkg::OTP_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Supply comparators
   input wire logic vcc_above_on,
   input wire logic vcc_below_off,
   input wire logic vcc_below_off_bo,
   input wire logic vcc_above_brownin,
   input wire logic vcc_above_ovp,
   // Line sense comparators
   input wire logic line_above_brownin,
   input wire logic line_below_brownout,
   // Current sense comparators
   input wire logic cs_above_peak_limit,
   input wire logic cs_above_severe,
   // Feedback and temperature
   input wire logic feedback_above_high,
   input wire logic die_above_trip,
   input wire logic die_below_release,
   // Faults detected elsewhere, one-cycle pulses, and the output OVP latch select, a level
   input wire logic output_overvoltage_fault,
   input wire logic output_ovp_latch_sel,
   input wire logic overload_fault,
   input wire logic sense_pin_short_fault,
   // Modulator
   input wire logic gate_request,
   input wire logic soft_start_done,
   input wire logic sleep_phase,
   // Power stage control
   output logic main_gate_drive,
   output logic startup_cell_on,
   output logic chip_active,
   output logic sensing_active,
   // Status
   output logic auto_restart_active,
   output logic latched_off_state,
   output logic low_line_shutdown,
   output logic cycle_peak_current_limit,
   output fps_pkg::fps_cause_type fault_cause
);

   fps_state_type state;
   fps_state_type next_state;
   fps_cause_type next_cause;
   logic switching;
   logic sensing;
   logic on_trip;
   logic off_trip;
   logic bo_trip;
   logic sev_trip;
   logic ovp_trip;
   logic fb_trip;
   logic otp_trip;
   logic ar_fault;
   logic latch_fault;
   logic bo_seen;
   logic otp_hold;
   logic ovp_cause;
   logic ar_done;
   logic [31:0] ar_count;
   logic [7:0] leb_count;
   logic pulse_ended;
   logic peak_hit;
   logic next_gate;
   logic next_cell;

   function automatic logic fps_is_switching(fps_state_type s);
      return (s == FPS_SOFT_START) || (s == FPS_NORMAL);
   endfunction

   assign switching = fps_is_switching(state);
   assign sensing = switching && !sleep_phase;

   // ==========================================================================
   // Blanking filters
   fps_blank_timer u_vcc_on (
      .sys_clk(sys_clk), .rst_n(rst_n), .cond(vcc_above_on),
      .limit(VCC_BLANK_LIMIT), .expired(on_trip));
   fps_blank_timer u_vcc_off (
      .sys_clk(sys_clk), .rst_n(rst_n), .cond(bo_seen ? vcc_below_off_bo : vcc_below_off),
      .limit(VCC_BLANK_LIMIT), .expired(off_trip));
   fps_blank_timer u_brownout (
      .sys_clk(sys_clk), .rst_n(rst_n), .cond(sensing && line_below_brownout),
      .limit(state == FPS_SOFT_START ? BO_SS_CYCLES[31:0] : BO_NORM_CYCLES[31:0]),
      .expired(bo_trip));
   fps_blank_timer u_severe (
      .sys_clk(sys_clk), .rst_n(rst_n), .cond(sensing && cs_above_severe),
      .limit(state == FPS_SOFT_START ? SEV_SS_LIMIT : SEV_NORM_LIMIT),
      .expired(sev_trip));
   fps_blank_timer u_supply_ovp (
      .sys_clk(sys_clk), .rst_n(rst_n), .cond(sensing && vcc_above_ovp),
      .limit(SUP_OVP_CYCLES[31:0]), .expired(ovp_trip));
   fps_blank_timer u_feedback (
      .sys_clk(sys_clk), .rst_n(rst_n), .cond(sensing && feedback_above_high),
      .limit(FB_HIGH_CYCLES[31:0]), .expired(fb_trip));
   fps_blank_timer u_overtemp (
      .sys_clk(sys_clk), .rst_n(rst_n), .cond(sensing && die_above_trip),
      .limit(OTP_CYCLES[31:0]), .expired(otp_trip));

   // ==========================================================================
   // Fault reactions
   assign latch_fault = sensing && output_overvoltage_fault && output_ovp_latch_sel;
   assign ar_fault = sev_trip || ovp_trip || fb_trip || otp_trip ||
      (sensing && (overload_fault || sense_pin_short_fault ||
      (output_overvoltage_fault && !output_ovp_latch_sel)));
   assign ar_done = ar_count >= AR_OFF_CYCLES[31:0];

   always_comb begin
      next_state = state;
      next_cause = fault_cause;
      case (state)
         FPS_OFF: begin
            if (on_trip) begin
               next_state = FPS_WAIT_LINE;
            end
         end
         FPS_WAIT_LINE: begin
            // Unfiltered comparators, so start waits on no blanking time; a line dip below brown-in holds it off
            if (line_above_brownin && vcc_above_brownin && !otp_hold) begin
               next_state = FPS_SOFT_START;
            end
         end
         FPS_SOFT_START, FPS_NORMAL: begin
            if (latch_fault) begin
               next_state = FPS_LATCHED;
               next_cause = FPS_CAUSE_OUTPUT_OVP;
            end else if (ar_fault) begin
               next_state = FPS_AUTO_RESTART;
               if (sev_trip) begin
                  next_cause = FPS_CAUSE_SEVERE_CURRENT;
               end else if (ovp_trip) begin
                  next_cause = FPS_CAUSE_SUPPLY_OVP;
               end else if (fb_trip) begin
                  next_cause = FPS_CAUSE_FEEDBACK_HIGH;
               end else if (otp_trip) begin
                  next_cause = FPS_CAUSE_DIE_OVERTEMP;
               end else if (output_overvoltage_fault) begin
                  next_cause = FPS_CAUSE_OUTPUT_OVP;
               end else if (overload_fault) begin
                  next_cause = FPS_CAUSE_OVERLOAD;
               end else begin
                  next_cause = FPS_CAUSE_SENSE_SHORT;
               end
            end else if (bo_trip) begin
               next_state = FPS_LOW_LINE;
               next_cause = FPS_CAUSE_LOW_LINE;
            end else if (state == FPS_SOFT_START && soft_start_done) begin
               next_state = FPS_NORMAL;
            end
         end
         FPS_AUTO_RESTART: begin
            if (ovp_cause && !vcc_above_ovp) begin
               next_state = FPS_WAIT_LINE;
            end else if (ar_done && on_trip) begin
               next_state = FPS_WAIT_LINE;
            end
         end
         FPS_LATCHED: begin
            next_state = FPS_LATCHED;
         end
         FPS_LOW_LINE: begin
            next_state = FPS_LOW_LINE;
         end
         default: begin
            next_state = FPS_OFF;
         end
      endcase
      // Lockout overrides every other state
      if (state != FPS_OFF && off_trip) begin
         next_state = FPS_OFF;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state <= FPS_OFF;
         fault_cause <= FPS_CAUSE_NONE;
      end else begin
         state <= next_state;
         fault_cause <= next_cause;
      end
   end

   // ==========================================================================
   // Fault memory
   always_ff @(posedge sys_clk) begin
      if (!rst_n || state == FPS_OFF) begin
         bo_seen <= 1'b0;
      end else if (next_state == FPS_LOW_LINE) begin
         bo_seen <= 1'b1;
      end
   end

   // Set wins over release; release is only sampled in the wait-line state
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         otp_hold <= 1'b0;
      end else if (otp_trip) begin
         otp_hold <= 1'b1;
      end else if (state == FPS_WAIT_LINE && die_below_release) begin
         otp_hold <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n || next_state != FPS_AUTO_RESTART) begin
         ovp_cause <= 1'b0;
      end else if (switching && next_cause == FPS_CAUSE_SUPPLY_OVP) begin
         ovp_cause <= 1'b1;
      end
   end

   // ==========================================================================
   // Auto-restart off-time
   always_ff @(posedge sys_clk) begin
      if (!rst_n || state != FPS_AUTO_RESTART) begin
         ar_count <= 32'h0;
      end else if (!ar_done) begin
         ar_count <= ar_count + 32'h1;
      end
   end

   // ==========================================================================
   // Gate pulse with leading-edge blanking and peak limit
   assign peak_hit = main_gate_drive && (leb_count == LEB_COUNT) && cs_above_peak_limit;

   always_ff @(posedge sys_clk) begin
      if (!rst_n || !main_gate_drive) begin
         leb_count <= 8'h00;
      end else if (leb_count != LEB_COUNT) begin
         leb_count <= leb_count + 8'h01;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n || !gate_request) begin
         pulse_ended <= 1'b0;
      end else if (peak_hit) begin
         pulse_ended <= 1'b1;
      end
   end

   // Gate follows the next state so a fault stops it in the same edge
   assign next_gate = fps_is_switching(next_state) && gate_request && !pulse_ended && !peak_hit;

   // ==========================================================================
   // Startup cell: full charge when off, hysteretic hold in auto-restart and latched, off in every other state
   always_comb begin
      next_cell = startup_cell_on;
      case (next_state)
         FPS_OFF: begin
            next_cell = 1'b1;
         end
         FPS_AUTO_RESTART: begin
            if (vcc_above_on) begin
               next_cell = 1'b0;
            end else if (!vcc_above_brownin) begin
               next_cell = 1'b1;
            end
         end
         FPS_LATCHED: begin
            // Wider band than auto-restart, so less startup cell loss
            if (vcc_above_on) begin
               next_cell = 1'b0;
            end else if (vcc_below_off_bo) begin
               next_cell = 1'b1;
            end
         end
         default: begin
            next_cell = 1'b0;
         end
      endcase
   end

   // ==========================================================================
   // Output flops
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         main_gate_drive <= 1'b0;
         startup_cell_on <= 1'b1;
         chip_active <= 1'b0;
         sensing_active <= 1'b0;
         auto_restart_active <= 1'b0;
         latched_off_state <= 1'b0;
         low_line_shutdown <= 1'b0;
         cycle_peak_current_limit <= 1'b0;
      end else begin
         main_gate_drive <= next_gate;
         startup_cell_on <= next_cell;
         chip_active <= next_state != FPS_OFF;
         sensing_active <= fps_is_switching(next_state) && !sleep_phase;
         auto_restart_active <= next_state == FPS_AUTO_RESTART;
         latched_off_state <= next_state == FPS_LATCHED;
         low_line_shutdown <= next_state == FPS_LOW_LINE;
         cycle_peak_current_limit <= peak_hit;
      end
   end

   // ==========================================================================
   // Assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_fault_seen;
      switching && ar_fault && !latch_fault && !off_trip;
   endsequence
   sequence s_in_restart;
      state == FPS_AUTO_RESTART;
   endsequence

   property p_gate_only_switching;
      !fps_is_switching(state) |-> !main_gate_drive;
   endproperty
   a_gate_only_switching: assert property (p_gate_only_switching) else $error("gate high outside switching");

   property p_fault_restart;
      s_fault_seen |=> s_in_restart ##0 !main_gate_drive;
   endproperty
   a_fault_restart: assert property (p_fault_restart) else $error("fault did not enter auto-restart");

   property p_restart_hold;
      s_in_restart ##0 (!ar_done && !off_trip && !ovp_cause) |=> s_in_restart;
   endproperty
   a_restart_hold: assert property (p_restart_hold) else $error("auto-restart left early");

   property p_latch_sticky;
      state == FPS_LATCHED && !off_trip |=> state == FPS_LATCHED && !main_gate_drive;
   endproperty
   a_latch_sticky: assert property (p_latch_sticky) else $error("latch mode left");

   property p_cell_charge;
      state == FPS_OFF |-> startup_cell_on;
   endproperty
   a_cell_charge: assert property (p_cell_charge) else $error("startup cell off while deactivated");

   property p_cell_regulate;
      state == FPS_AUTO_RESTART && $past(state) == FPS_AUTO_RESTART && !off_trip && !vcc_above_brownin
         |=> startup_cell_on;
   endproperty
   a_cell_regulate: assert property (p_cell_regulate) else $error("startup cell not recharging");

   property p_brownin_start;
      state == FPS_WAIT_LINE && line_above_brownin && vcc_above_brownin && !otp_hold && !off_trip
         |=> state == FPS_SOFT_START;
   endproperty
   a_brownin_start: assert property (p_brownin_start) else $error("soft-start not begun");

   property p_brownin_block;
      state == FPS_WAIT_LINE && !(line_above_brownin && vcc_above_brownin) |=> !main_gate_drive;
   endproperty
   a_brownin_block: assert property (p_brownin_block) else $error("switching without brown-in");

   property p_peak_end;
      cycle_peak_current_limit |-> !main_gate_drive ##1 (!main_gate_drive || !$past(gate_request));
   endproperty
   a_peak_end: assert property (p_peak_end) else $error("gate not ended at peak");

   property p_leb_mask;
      $rose(main_gate_drive) |=> !cycle_peak_current_limit [*2];
   endproperty
   a_leb_mask: assert property (p_leb_mask) else $error("peak limit inside blanking");

   property p_sleep_no_sense;
      sleep_phase |=> !sensing_active;
   endproperty
   a_sleep_no_sense: assert property (p_sleep_no_sense) else $error("sensing during sleep");

   property p_lockout;
      state != FPS_OFF && off_trip |=> state == FPS_OFF && !chip_active;
   endproperty
   a_lockout: assert property (p_lockout) else $error("lockout did not deactivate");

endmodule // fps_supervisor

/* design/fps_pkg.sv */
// Constants, timing counts, state and fault codes of the flyback protection supervisor.
// Assumes a single 250 MHz system clock; all times are converted to cycles here.
package fps_pkg;

   // ==========================================================================
   // Clock
   localparam longint unsigned CLK_PERIOD_PS = 64'd4000;

   // Least times round up to whole cycles, never below one
   function automatic int unsigned fps_ceil_cyc(longint unsigned t_ps);
      longint unsigned c;
      c = (t_ps + CLK_PERIOD_PS - 64'd1) / CLK_PERIOD_PS;
      if (c == 64'd0) begin
         c = 64'd1;
      end
      return int'(c[31:0]);
   endfunction

   // ==========================================================================
   // Times as printed, in picoseconds
   localparam longint unsigned AR_OFF_PS = 64'd3_000_000_000_000;
   localparam longint unsigned BO_NORM_PS = 64'd1_090_000_000;
   localparam longint unsigned BO_SS_PS = 64'd5_270_000_000;
   localparam longint unsigned SEV_NORM_PS = 64'd616_200;
   localparam longint unsigned SEV_SS_PS = 64'd1_001_000;
   localparam longint unsigned SUP_OVP_PS = 64'd100_000_000;
   localparam longint unsigned FB_HIGH_PS = 64'd31_300_000_000;
   localparam longint unsigned OTP_PS = 64'd10_500_000_000;
   localparam longint unsigned LEB_PS = 64'd283_000;
   // Supply spike blanking, value not given: plain default
   localparam longint unsigned VCC_BLANK_PS = 64'd1_000_000;

   // ==========================================================================
   // Derived cycle counts
   localparam int unsigned AR_OFF_CYC = fps_ceil_cyc(AR_OFF_PS);
   localparam int unsigned BO_NORM_CYC = fps_ceil_cyc(BO_NORM_PS);
   localparam int unsigned BO_SS_CYC = fps_ceil_cyc(BO_SS_PS);
   localparam int unsigned SEV_NORM_CYC = fps_ceil_cyc(SEV_NORM_PS);
   localparam int unsigned SEV_SS_CYC = fps_ceil_cyc(SEV_SS_PS);
   localparam int unsigned SUP_OVP_CYC = fps_ceil_cyc(SUP_OVP_PS);
   localparam int unsigned FB_HIGH_CYC = fps_ceil_cyc(FB_HIGH_PS);
   localparam int unsigned OTP_CYC = fps_ceil_cyc(OTP_PS);
   localparam int unsigned LEB_CYC = fps_ceil_cyc(LEB_PS);
   localparam int unsigned VCC_BLANK_CYC = fps_ceil_cyc(VCC_BLANK_PS);
   localparam logic [7:0] LEB_COUNT = LEB_CYC[7:0];
   localparam logic [31:0] SEV_NORM_LIMIT = SEV_NORM_CYC[31:0];
   localparam logic [31:0] SEV_SS_LIMIT = SEV_SS_CYC[31:0];
   localparam logic [31:0] VCC_BLANK_LIMIT = VCC_BLANK_CYC[31:0];

   // ==========================================================================
   // Operating states, one-hot
   typedef enum logic [6:0] {
      FPS_OFF = 7'h01,
      FPS_WAIT_LINE = 7'h02,
      FPS_SOFT_START = 7'h04,
      FPS_NORMAL = 7'h08,
      FPS_AUTO_RESTART = 7'h10,
      FPS_LATCHED = 7'h20,
      FPS_LOW_LINE = 7'h40
   } fps_state_type;

   // ==========================================================================
   // Cause of the last protective stop
   typedef enum logic [3:0] {
      FPS_CAUSE_NONE = 4'h0,
      FPS_CAUSE_SEVERE_CURRENT = 4'h1,
      FPS_CAUSE_SUPPLY_OVP = 4'h2,
      FPS_CAUSE_FEEDBACK_HIGH = 4'h3,
      FPS_CAUSE_DIE_OVERTEMP = 4'h4,
      FPS_CAUSE_OUTPUT_OVP = 4'h5,
      FPS_CAUSE_OVERLOAD = 4'h6,
      FPS_CAUSE_SENSE_SHORT = 4'h7,
      FPS_CAUSE_LOW_LINE = 4'h8
   } fps_cause_type;

endpackage

/* design/fps_blank_timer.sv */
// Blanking timer: qualifies a condition that has held for more than a limit of cycles.
// Assumes the condition is synchronous to sys_clk.
module fps_blank_timer
   import fps_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Condition and limit
   input wire logic cond,
   input wire logic [31:0] limit,
   // Qualified result
   output logic expired
);

   logic [31:0] count;

   // ==========================================================================
   // Counter restarts from zero whenever the condition drops
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !cond) begin
         count <= 32'h0;
      end else if (count < limit) begin
         count <= count + 32'h1;
      end
   end

   assign expired = cond && (count >= limit);

endmodule // fps_blank_timer

/* verif/fps_analog_model.sv */
// Comparator model of the power stage: supply, line, sense, feedback, die.
// Assumes levels in mV, uA and deg C set by the bench; outputs settle at once.
module fps_analog_model (
   // Levels
   input wire logic [15:0] vcc_mv,
   input wire logic [15:0] line_ua,
   input wire logic [15:0] cs_mv,
   input wire logic [15:0] fb_mv,
   input wire logic [15:0] die_c,
   // Comparator results
   output logic vcc_above_on,
   output logic vcc_below_off,
   output logic vcc_below_off_bo,
   output logic vcc_above_brownin,
   output logic vcc_above_ovp,
   output logic line_above_brownin,
   output logic line_below_brownout,
   output logic cs_above_peak_limit,
   output logic cs_above_severe,
   output logic feedback_above_high,
   output logic die_above_trip,
   output logic die_below_release
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Thresholds
   assign vcc_above_on = vcc_mv > 16'd20500;
   assign vcc_below_off = vcc_mv < 16'd7200;
   assign vcc_below_off_bo = vcc_mv < 16'd9600;
   assign vcc_above_brownin = vcc_mv > 16'd15000;
   assign vcc_above_ovp = vcc_mv > 16'd21800;
   assign line_above_brownin = line_ua > 16'd1150;
   assign line_below_brownout = line_ua < 16'd443;
   assign cs_above_peak_limit = cs_mv >= 16'd402;
   assign cs_above_severe = cs_mv > 16'd600;
   assign feedback_above_high = fb_mv > 16'd2410;
   assign die_above_trip = die_c > 16'd130;
   // Release sits 20 C under the trip level
   assign die_below_release = die_c < 16'd110;
endmodule // fps_analog_model

/* verif/fps_supervisor_test.sv */
// Self-checking bench of the protection supervisor.
// Assumes the comparator model drives all analog inputs; short sim timing parameters.
module fps_supervisor_test;
   timeunit 1ns;
   timeprecision 1ps;
   import fps_pkg::*;
   // ==========================================================
   // Signals
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] vcc_mv = 16'd0, line_ua = 16'd0, cs_mv = 16'd0, fb_mv = 16'd0, die_c = 16'd25;
   logic vcc_above_on, vcc_below_off, vcc_below_off_bo, vcc_above_brownin, vcc_above_ovp;
   logic line_above_brownin, line_below_brownout, cs_above_peak_limit, cs_above_severe;
   logic feedback_above_high, die_above_trip, die_below_release;
   logic output_overvoltage_fault = 1'b0, output_ovp_latch_sel = 1'b0, overload_fault = 1'b0;
   logic sense_pin_short_fault = 1'b0, gate_request = 1'b0, soft_start_done = 1'b0, sleep_phase = 1'b0;
   logic main_gate_drive, startup_cell_on, chip_active, sensing_active, auto_restart_active;
   logic latched_off_state, low_line_shutdown, cycle_peak_current_limit;
   fps_cause_type fault_cause;
   int errors = 0;
   int compares = 0;
   localparam int AR = 50;
   initial begin
      forever #2 sys_clk = ~sys_clk;
   end
   fps_analog_model fps_analog_model_i (.vcc_mv, .line_ua, .cs_mv, .fb_mv, .die_c, .vcc_above_on,
      .vcc_below_off, .vcc_below_off_bo, .vcc_above_brownin, .vcc_above_ovp, .line_above_brownin,
      .line_below_brownout, .cs_above_peak_limit, .cs_above_severe, .feedback_above_high,
      .die_above_trip, .die_below_release);
   fps_supervisor #(.AR_OFF_CYCLES(AR), .BO_NORM_CYCLES(20), .BO_SS_CYCLES(40), .SUP_OVP_CYCLES(10),
      .FB_HIGH_CYCLES(30), .OTP_CYCLES(25)) fps_supervisor_i (.sys_clk, .rst_n, .vcc_above_on,
      .vcc_below_off, .vcc_below_off_bo, .vcc_above_brownin, .vcc_above_ovp, .line_above_brownin,
      .line_below_brownout, .cs_above_peak_limit, .cs_above_severe, .feedback_above_high,
      .die_above_trip, .die_below_release, .output_overvoltage_fault, .output_ovp_latch_sel,
      .overload_fault, .sense_pin_short_fault, .gate_request, .soft_start_done, .sleep_phase,
      .main_gate_drive, .startup_cell_on, .chip_active, .sensing_active, .auto_restart_active,
      .latched_off_state, .low_line_shutdown, .cycle_peak_current_limit, .fault_cause);
   // ==========================================================
   // Helpers
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic complete_run();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Reset, then power up into normal operation
   task automatic boot(input logic ss = 1'b1);
      rst_n = 1'b0;
      {vcc_mv, line_ua, cs_mv, fb_mv, die_c} = {16'd0, 16'd500, 16'd0, 16'd0, 16'd25};
      {gate_request, soft_start_done, sleep_phase, output_ovp_latch_sel} = 4'h0;
      tick(16);
      rst_n = 1'b1;
      vcc_mv = 16'd21000;
      tick(VCC_BLANK_CYC - 5);
      check(chip_active, 1'b0);
      tick(10);
      check(chip_active, 1'b1);
      check(sensing_active, 1'b0);
      line_ua = 16'd2000;
      tick(2);
      check(sensing_active, 1'b1);
      soft_start_done = ss;
      tick(2);
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_peak();
      boot();
      gate_request = 1'b1;
      tick(LEB_CYC - 8);
      cs_mv = 16'd450;
      tick(4);
      check(main_gate_drive, 1'b1);
      tick(6);
      check({main_gate_drive, cycle_peak_current_limit}, 2'b01);
      tick(1);
      check({main_gate_drive, cycle_peak_current_limit}, 2'b00);
      gate_request = 1'b0;
      cs_mv = 16'd0;
      tick(2);
      gate_request = 1'b1;
      tick(2);
      check(main_gate_drive, 1'b1);
      $display("peak limit done");
   endtask
   task automatic t_severe();
      cs_mv = 16'd700;
      tick(SEV_NORM_CYC - 5);
      check(auto_restart_active, 1'b0);
      tick(8);
      check({auto_restart_active, main_gate_drive, fault_cause}, {2'b10, FPS_CAUSE_SEVERE_CURRENT});
      cs_mv = 16'd0;
      check(startup_cell_on, 1'b0);
      vcc_mv = 16'd14000;
      tick(2);
      check(startup_cell_on, 1'b1);
      vcc_mv = 16'd21000;
      tick(AR + VCC_BLANK_CYC + 8);
      check({auto_restart_active, sensing_active}, 2'b01);
      $display("severe current done");
   endtask
   // Timed faults: 0 feedback, 1 die, 2 supply, 3 severe current in soft-start
   task automatic apply(input int k, input logic on);
      case (k)
         0: fb_mv = on ? 16'd2500 : 16'd0;
         1: die_c = on ? 16'd140 : 16'd120;
         2: vcc_mv = on ? 16'd22000 : 16'd21000;
         default: cs_mv = on ? 16'd700 : 16'd0;
      endcase
   endtask
   task automatic t_timed(input int k, input int lim, input fps_cause_type cause);
      boot(k != 3);
      apply(k, 1'b1);
      tick(lim - 3);
      apply(k, 1'b0);
      tick(2);
      apply(k, 1'b1);
      tick(lim - 3);
      check(auto_restart_active, 1'b0);
      tick(6);
      check({auto_restart_active, main_gate_drive, fault_cause}, {2'b10, cause});
      apply(k, 1'b0);
      tick(k == 2 ? 5 : AR + VCC_BLANK_CYC + 10);
      check(auto_restart_active, 1'b0);
      check(sensing_active, k != 1);
      die_c = 16'd100;
      tick(4);
      check(sensing_active, 1'b1);
      $display("timed fault %0d done", k);
   endtask
   task automatic t_brownout();
      // Soft-start limit first, then the normal one
      for (int m = 0; m < 2; m++) begin
         boot(m == 1);
         line_ua = 16'd300;
         tick(m == 1 ? 17 : 37);
         check(low_line_shutdown, 1'b0);
         tick(6);
         check({low_line_shutdown, main_gate_drive}, 2'b10);
      end
      vcc_mv = 16'd9000;
      tick(VCC_BLANK_CYC + 6);
      check({chip_active, startup_cell_on}, 2'b01);
      $display("brown-out done");
   endtask
   task automatic t_sleep();
      boot();
      sleep_phase = 1'b1;
      fb_mv = 16'd2500;
      tick(40);
      check({sensing_active, auto_restart_active}, 2'b00);
      $display("sleep done");
   endtask
   // External faults: 0 overload, 1 short, 2 output OVP restart, 3 output OVP latch
   task automatic t_ext();
      for (int k = 0; k < 4; k++) begin
         boot();
         output_ovp_latch_sel = (k == 3);
         {output_overvoltage_fault, sense_pin_short_fault, overload_fault} = {k > 1, k == 1, k == 0};
         tick(1);
         {output_overvoltage_fault, sense_pin_short_fault, overload_fault} = 3'h0;
         tick(2);
         check({auto_restart_active, latched_off_state, main_gate_drive}, {k != 3, k == 3, 1'b0});
         check(fault_cause, k == 0 ? FPS_CAUSE_OVERLOAD : k == 1 ? FPS_CAUSE_SENSE_SHORT : FPS_CAUSE_OUTPUT_OVP);
      end
      check(startup_cell_on, 1'b0);
      vcc_mv = 16'd9000;
      tick(2);
      check(startup_cell_on, 1'b1);
      vcc_mv = 16'd7000;
      tick(VCC_BLANK_CYC + 6);
      check(chip_active, 1'b0);
      $display("external faults done");
   endtask
   // ==========================================================
   // Sequence and watchdog
   initial begin
      t_peak();
      t_severe();
      t_timed(0, 30, FPS_CAUSE_FEEDBACK_HIGH);
      t_timed(1, 25, FPS_CAUSE_DIE_OVERTEMP);
      t_timed(2, 10, FPS_CAUSE_SUPPLY_OVP);
      t_timed(3, SEV_SS_CYC, FPS_CAUSE_SEVERE_CURRENT);
      t_brownout();
      t_sleep();
      t_ext();
      complete_run();
   end
   initial begin
      #200us;
      errors++;
      complete_run();
   end
endmodule // fps_supervisor_test
